/* File: src/mal_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: Included by the memory access block
`ifndef MAL_MAP_SVH
`define MAL_MAP_SVH
// ----------------------------------------
// Memory pages
// ----------------------------------------
`define MAL_PG_TEST 3'h0
`define MAL_PG_RAM 3'h1
`define MAL_PG_FREG 3'h2
`define MAL_PG_OTP_LO 3'h3
`define MAL_PG_OTP_HI 3'h4
`define MAL_PG_EE 3'h5
`define MAL_OTP_BYTES 8192
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define MAL_TR_CTRL 8'h00
`define MAL_CTRL_CORE_RST 0
`define MAL_CTRL_MEM_SEL 1
`define MAL_EXT_BASE 8'h80
`define MAL_FR_PROTO 8'hf0
`define MAL_FR_EE_ACC 8'hf1
`define MAL_FR_EE_CMD 8'hf2
`define MAL_FR_EE_STAT 8'hf3
`define MAL_ACC_OWNER 0
`define MAL_CMD_LOAD 0
`define MAL_CMD_PROG 1
`define MAL_STAT_BUSY 0
`define MAL_STAT_CRC_ERR 1
`define MAL_PROTO_I2C 2'h1
`define MAL_PROTO_RST 2'h0
`define MAL_CTRL_RST 2'h0
// ----------------------------------------
// Lock codes and cache map
// ----------------------------------------
`define MAL_LOCK_CODE 8'haa
`define MAL_UNLOCK_CODE 8'h00
`define MAL_CACHE_TAG 8'h55
`define MAL_NUM_BANKS 6
`define MAL_CRC_INIT 8'hff
`define MAL_CRC_POLY 8'h07
// ----------------------------------------
// Timing
// ----------------------------------------
`define MAL_CLK_MHZ 100
`define MAL_PROG_TIME_US 10
`define MAL_PROG_CYC (`MAL_PROG_TIME_US * `MAL_CLK_MHZ)
`endif

/* File: src/mal_pkg.sv */
// Purpose: Types of the memory access block
// Assumes: Nothing
// Notes: One-hot state codes
package mal_pkg;
  typedef enum logic [3:0] {
    MAL_IDLE = 4'h1,
    MAL_LOAD = 4'h2,
    MAL_PROG = 4'h4,
    MAL_CHECK = 4'h8
  } mal_state_t;
endpackage

/* File: src/mal_mem_access.sv */
// Purpose: Memory page map, interface lock, EEPROM cache and banks
// Assumes: Serial and core requests are one-cycle pulses on clk_sys
// Notes: Core request has priority over serial request
//
// Functional notes
// - Sample data while clock high only
// - Program memory 8 kB at pages 3-4
// - Lock code 0xAA refuses serial memory reads
// - Lock also blocks serial control test register
// - Code 0x00 while locked reopens memories
// - Core keeps full access while locked
// - Watchdog core reset keeps the lock
// - Six banks at page 5 through cache
// - Byte access, eight-byte one-wire burst
// - Owner bit chooses serial or core cache
// - Cache load moves 128 bits from bank
// - Cache held stable during programming
// - Bank 0 16 bytes, both, no CRC
// - Banks 1-4 programmed by serial only (core can load), 128 bits
// - Banks 1-4 CRC stored and validated
// - Bank 5 cumulative CRC at 0x558 validated
// - Scratch RAM 256 bytes at page 1
// - Serial reaches only external function registers
// - Test page 0 serial only
// - Serial needs memory select outside test
`timescale 1ns/100ps
`include "mal_map.svh"
module mal_mem_access
  import mal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic core_wdt_rst,
  input wire logic [7:0] lock_code_port,
  input wire logic si_req,
  input wire logic si_we,
  input wire logic si_burst,
  input wire logic [2:0] si_page,
  input wire logic [11:0] si_addr,
  input wire logic [7:0] si_wdata,
  input wire logic [63:0] si_bwdata,
  output logic si_rdy,
  output logic si_ack_ff,
  output logic si_err_ff,
  output logic [7:0] si_rdata_ff,
  output logic [63:0] si_brdata_ff,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [2:0] cpu_page,
  input wire logic [11:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_rdy,
  output logic cpu_ack_ff,
  output logic cpu_err_ff,
  output logic [7:0] cpu_rdata_ff,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  input wire logic i2c_tx_low,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_ff,
  output logic i2c_bit_vld_ff,
  output logic i2c_bit_ff,
  output logic i2c_start_ff,
  output logic i2c_stop_ff,
  output logic core_reset,
  output logic locked_ff,
  output logic [1:0] interface_protocol_select
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0] ctrl_ff;
  logic [1:0] proto_ff;
  logic owner_ff;
  logic [2:0] bank_sel_ff;
  logic crc_err_ff;
  logic [7:0] ram_ff [0:255];
  logic [7:0] otp_ff [0:`MAL_OTP_BYTES-1];
  logic [127:0] bank_ff [0:`MAL_NUM_BANKS-1];
  logic [7:0] crc_ff [0:`MAL_NUM_BANKS-1];
  logic [7:0] cache_ff [0:15];
  mal_state_t state_ff;
  mal_state_t nxt_state;
  logic [15:0] prog_cnt_ff;
  logic [2:0] op_bank_ff;
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `MAL_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] crc_blk(input logic [7:0] c, input logic [127:0] d,
                                         input int n);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 16; i++) begin
      if (i < n) begin
        r = crc_byte(r, d[i*8 +: 8]);
      end
    end
    return r;
  endfunction

  function automatic logic [127:0] cache_word();
    logic [127:0] w;
    w = '0;
    for (int i = 0; i < 16; i++) begin
      w[i*8 +: 8] = cache_ff[i];
    end
    return w;
  endfunction

  // ----------------------------------------
  // Arbitration and permission
  // ----------------------------------------
  logic busy;
  logic g_cpu, g_si;
  logic [2:0] g_page;
  logic [11:0] g_addr;
  logic g_we;
  logic [7:0] g_wdata;
  logic si_ok, cpu_ok, g_ok;
  logic si_cache, cpu_cache;

  assign busy = (state_ff != MAL_IDLE);
  assign cpu_rdy = 1'b1;
  assign si_rdy = ~cpu_req;
  assign g_cpu = cpu_req & ~ctrl_ff[`MAL_CTRL_CORE_RST];
  assign g_si = si_req & ~cpu_req;
  assign g_page = g_cpu ? cpu_page : si_page;
  assign g_addr = g_cpu ? cpu_addr : si_addr;
  assign g_we = g_cpu ? cpu_we : si_we;
  assign g_wdata = g_cpu ? cpu_wdata : si_wdata;
  assign si_cache = (si_addr[11:4] == `MAL_CACHE_TAG) & owner_ff;
  assign cpu_cache = (cpu_addr[11:4] == `MAL_CACHE_TAG) & ~owner_ff;

  always_comb begin
    si_ok = 1'b0;
    if (si_page == `MAL_PG_TEST) begin
      si_ok = ~(locked_ff & (si_addr[7:0] == `MAL_TR_CTRL));
    end else if (ctrl_ff[`MAL_CTRL_MEM_SEL] & ~locked_ff) begin
      unique case (si_page)
        `MAL_PG_RAM: si_ok = 1'b1;
        `MAL_PG_FREG: si_ok = (si_addr[7:0] >= `MAL_EXT_BASE);
        `MAL_PG_OTP_LO, `MAL_PG_OTP_HI: si_ok = 1'b1;
        `MAL_PG_EE: si_ok = si_cache & ~(si_we & busy);
        default: si_ok = 1'b0;
      endcase
    end
    if (si_burst & ~(si_page == `MAL_PG_EE & si_cache & si_addr[2:0] == 3'h0)) begin
      si_ok = 1'b0;
    end
  end

  always_comb begin
    cpu_ok = 1'b0;
    unique case (cpu_page)
      `MAL_PG_TEST: cpu_ok = 1'b0;
      `MAL_PG_RAM: cpu_ok = 1'b1;
      `MAL_PG_FREG: cpu_ok = 1'b1;
      `MAL_PG_OTP_LO, `MAL_PG_OTP_HI: cpu_ok = ~cpu_we;
      `MAL_PG_EE: cpu_ok = cpu_cache & ~(cpu_we & busy);
      default: cpu_ok = 1'b0;
    endcase
  end

  assign g_ok = g_cpu ? cpu_ok : si_ok;

  // ----------------------------------------
  // Lock
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      locked_ff <= 1'b0;
    end else if (lock_code_port == `MAL_LOCK_CODE) begin
      locked_ff <= 1'b1;
    end else if (locked_ff & (lock_code_port == `MAL_UNLOCK_CODE)) begin
      locked_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic wr_ok;
  logic cmd_wr;
  logic cmd_load, cmd_prog, cmd_allowed;
  assign wr_ok = (g_cpu | g_si) & g_ok & g_we;
  assign cmd_wr = wr_ok & (g_page == `MAL_PG_FREG) & (g_addr[7:0] == `MAL_FR_EE_CMD);
  assign cmd_load = cmd_wr & g_wdata[`MAL_CMD_LOAD] & ~busy;
  assign cmd_allowed = g_si | (bank_sel_ff == 3'h0);
  assign cmd_prog = cmd_wr & g_wdata[`MAL_CMD_PROG] & ~busy & cmd_allowed;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= `MAL_CTRL_RST;
    end else if (g_si & si_ok & si_we & (si_page == `MAL_PG_TEST) &
                 (si_addr[7:0] == `MAL_TR_CTRL)) begin
      ctrl_ff <= si_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      proto_ff <= `MAL_PROTO_RST;
      owner_ff <= 1'b0;
      bank_sel_ff <= 3'h0;
    end else if (wr_ok & (g_page == `MAL_PG_FREG)) begin
      if (g_addr[7:0] == `MAL_FR_PROTO) begin
        proto_ff <= g_wdata[1:0];
      end
      if (g_addr[7:0] == `MAL_FR_EE_ACC & ~busy) begin
        owner_ff <= g_wdata[`MAL_ACC_OWNER];
        bank_sel_ff <= g_wdata[3:1];
      end
    end
  end

  assign core_reset = ctrl_ff[`MAL_CTRL_CORE_RST] | core_wdt_rst;
  assign interface_protocol_select = proto_ff;

  // ----------------------------------------
  // Bank engine
  // ----------------------------------------
  logic [7:0] chk_crc;
  always_comb begin
    chk_crc = `MAL_CRC_INIT;
    for (int b = 1; b < 5; b++) begin
      chk_crc = crc_blk(chk_crc, bank_ff[b], 16);
    end
    chk_crc = crc_blk(chk_crc, bank_ff[5], 8);
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MAL_IDLE: begin
        if (cmd_prog) begin
          nxt_state = MAL_PROG;
        end else if (cmd_load) begin
          nxt_state = MAL_LOAD;
        end
      end
      MAL_LOAD: nxt_state = MAL_IDLE;
      MAL_PROG: begin
        if (prog_cnt_ff == 16'h0) begin
          nxt_state = MAL_CHECK;
        end
      end
      MAL_CHECK: nxt_state = MAL_IDLE;
      default: nxt_state = MAL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= MAL_IDLE;
      prog_cnt_ff <= 16'h0;
      op_bank_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == MAL_IDLE) begin
        op_bank_ff <= bank_sel_ff;
        prog_cnt_ff <= 16'(`MAL_PROG_CYC - 1);
      end else if (prog_cnt_ff != 16'h0) begin
        prog_cnt_ff <= prog_cnt_ff - 16'h1;
      end
    end
  end

  logic chk_fail;
  always_comb begin
    chk_fail = 1'b0;
    if (op_bank_ff >= 3'h1 && op_bank_ff <= 3'h4) begin
      chk_fail = crc_blk(`MAL_CRC_INIT, bank_ff[op_bank_ff], 16) != crc_ff[op_bank_ff];
    end else if (op_bank_ff == 3'h5) begin
      chk_fail = chk_crc != bank_ff[5][71:64];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (state_ff == MAL_PROG && prog_cnt_ff == 16'h0 && op_bank_ff < 3'h6) begin
      bank_ff[op_bank_ff] <= cache_word();
      if (op_bank_ff != 3'h0) begin
        crc_ff[op_bank_ff] <= crc_blk(`MAL_CRC_INIT, cache_word(), 16);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      crc_err_ff <= 1'b0;
    end else if (state_ff == MAL_CHECK && chk_fail) begin
      crc_err_ff <= 1'b1;
    end else if (wr_ok && g_page == `MAL_PG_FREG && g_addr[7:0] == `MAL_FR_EE_STAT &&
                 g_wdata[`MAL_STAT_CRC_ERR]) begin
      crc_err_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Memory writes
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (state_ff == MAL_LOAD && op_bank_ff < 3'h6) begin
      for (int i = 0; i < 16; i++) begin
        cache_ff[i] <= bank_ff[op_bank_ff][i*8 +: 8];
      end
    end else if (g_si & si_ok & si_we & si_burst) begin
      for (int i = 0; i < 8; i++) begin
        cache_ff[{si_addr[3], 3'(i)}] <= si_bwdata[i*8 +: 8];
      end
    end else if (wr_ok & (g_page == `MAL_PG_EE)) begin
      cache_ff[g_addr[3:0]] <= g_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_ok & (g_page == `MAL_PG_RAM)) begin
      ram_ff[g_addr[7:0]] <= g_wdata;
    end
    if (wr_ok & (g_page == `MAL_PG_OTP_LO || g_page == `MAL_PG_OTP_HI)) begin
      otp_ff[{g_page == `MAL_PG_OTP_HI, g_addr}] <= g_wdata;
    end
  end

  // ----------------------------------------
  // Read data and answers
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic [63:0] rd_burst;
  always_comb begin
    rd_byte = 8'h00;
    rd_burst = 64'h0;
    for (int i = 0; i < 8; i++) begin
      rd_burst[i*8 +: 8] = cache_ff[{g_addr[3], 3'(i)}];
    end
    unique case (g_page)
      `MAL_PG_TEST: rd_byte = (g_addr[7:0] == `MAL_TR_CTRL) ? {6'h0, ctrl_ff} : 8'h00;
      `MAL_PG_RAM: rd_byte = ram_ff[g_addr[7:0]];
      `MAL_PG_FREG: begin
        unique case (g_addr[7:0])
          `MAL_FR_PROTO: rd_byte = {6'h0, proto_ff};
          `MAL_FR_EE_ACC: rd_byte = {4'h0, bank_sel_ff, owner_ff};
          `MAL_FR_EE_STAT: rd_byte = {6'h0, crc_err_ff, busy};
          default: rd_byte = 8'h00;
        endcase
      end
      `MAL_PG_OTP_LO, `MAL_PG_OTP_HI: rd_byte = otp_ff[{g_page == `MAL_PG_OTP_HI, g_addr}];
      `MAL_PG_EE: rd_byte = cache_ff[g_addr[3:0]];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      si_ack_ff <= 1'b0;
      si_err_ff <= 1'b0;
      si_rdata_ff <= 8'h00;
      si_brdata_ff <= 64'h0;
      cpu_ack_ff <= 1'b0;
      cpu_err_ff <= 1'b0;
      cpu_rdata_ff <= 8'h00;
    end else begin
      si_ack_ff <= g_si;
      si_err_ff <= g_si & ~si_ok;
      cpu_ack_ff <= g_cpu;
      cpu_err_ff <= g_cpu & ~cpu_ok;
      if (g_si & si_ok & ~si_we) begin
        si_rdata_ff <= rd_byte;
        si_brdata_ff <= rd_burst;
      end
      if (g_cpu & cpu_ok & ~cpu_we) begin
        cpu_rdata_ff <= rd_byte;
      end
    end
  end

  // ----------------------------------------
  // Serial line sampler
  // ----------------------------------------
  logic i2c_on;
  assign i2c_on = (proto_ff == `MAL_PROTO_I2C);
  assign i2c_sda_out = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= i2c_scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= i2c_sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i2c_bit_vld_ff <= 1'b0;
      i2c_bit_ff <= 1'b0;
      i2c_start_ff <= 1'b0;
      i2c_stop_ff <= 1'b0;
      i2c_sda_oe_ff <= 1'b0;
    end else begin
      i2c_bit_vld_ff <= i2c_on & scl_s2_ff & ~scl_s3_ff;
      if (scl_s2_ff & ~scl_s3_ff) begin
        i2c_bit_ff <= sda_s2_ff;
      end
      i2c_start_ff <= i2c_on & scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
      i2c_stop_ff <= i2c_on & scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
      if (~i2c_on) begin
        i2c_sda_oe_ff <= 1'b0;
      end else if (~scl_s2_ff) begin
        i2c_sda_oe_ff <= i2c_tx_low;
      end
    end
  end
endmodule

/* File: test/mal_mem_access_chk.sv */
// Purpose: Port checks of the memory access block
// Assumes: Bound to mal_mem_access
// Notes: One clock domain
`timescale 1ns/100ps
module mal_mem_access_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic core_wdt_rst,
  input wire logic [7:0] lock_code_port,
  input wire logic si_req,
  input wire logic si_rdy,
  input wire logic [2:0] si_page,
  input wire logic [11:0] si_addr,
  input wire logic si_ack_ff,
  input wire logic si_err_ff,
  input wire logic cpu_req,
  input wire logic [2:0] cpu_page,
  input wire logic cpu_ack_ff,
  input wire logic cpu_err_ff,
  input wire logic core_reset,
  input wire logic locked_ff,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  input wire logic i2c_bit_vld_ff,
  input wire logic i2c_bit_ff,
  input wire logic i2c_sda_oe_ff
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence si_take;
    si_req && si_rdy;
  endsequence
  sequence scl_rise;
    $rose(i2c_scl_in);
  endsequence
  a_si_ack_pulse: assert property (si_take |=> si_ack_ff)
    else $error("serial ack missing");
  a_si_no_stray: assert property (!(si_req && si_rdy) |=> !si_ack_ff && !si_err_ff)
    else $error("serial ack without request");
  a_core_wins: assert property (cpu_req |-> !si_rdy)
    else $error("serial ready during core request");
  a_lock_enter: assert property (lock_code_port == 8'haa |=> locked_ff)
    else $error("lock not entered");
  a_lock_hold: assert property (locked_ff && lock_code_port != 8'h00 |=> locked_ff)
    else $error("lock lost");
  a_lock_open: assert property (locked_ff && lock_code_port == 8'h00 |=> !locked_ff)
    else $error("unlock ignored");
  a_lock_refuse: assert property ((si_take and (locked_ff && si_page != 3'h0)) |=> si_err_ff)
    else $error("locked access not refused");
  a_ctrl_guard: assert property ((si_take and (locked_ff && si_page == 3'h0 && si_addr == 12'h000))
    |=> si_err_ff)
    else $error("control register open while locked");
  a_core_no_test: assert property (cpu_req && !core_reset && cpu_page == 3'h0 |=> cpu_ack_ff && cpu_err_ff)
    else $error("core reached test page");
  a_bit_sample: assert property (scl_rise |-> ##3 (i2c_bit_vld_ff && i2c_bit_ff == $past(i2c_sda_in, 3)))
    else $error("data bit not sampled on clock rise");
  a_oe_scl_low: assert property ($changed(i2c_sda_oe_ff) |-> !$past(i2c_scl_in, 3))
    else $error("data driver changed while clock high");
  a_wdt_core: assert property (core_wdt_rst |-> core_reset)
    else $error("watchdog did not reset core");
endmodule
bind mal_mem_access mal_mem_access_chk chk_u (.clk_sys, .rst, .core_wdt_rst, .lock_code_port, .si_req, .si_rdy,
  .si_page, .si_addr, .si_ack_ff, .si_err_ff, .cpu_req, .cpu_page, .cpu_ack_ff, .cpu_err_ff, .core_reset,
  .locked_ff, .i2c_scl_in, .i2c_sda_in, .i2c_bit_vld_ff, .i2c_bit_ff, .i2c_sda_oe_ff);

/* File: test/mal_i2c_mst.sv */
// Purpose: Serial master on the two-wire bus
// Assumes: Pull-up on the data line
// Notes: Changes lines 1 ns after a clock edge
`timescale 1ns/100ps
module mal_i2c_mst (
  input wire logic clk_sys,
  input wire logic dut_oe,
  output logic scl,
  output logic sda
);
  logic drv_low;
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end
  assign sda = ~(drv_low | dut_oe);
  task automatic gap;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task automatic hold_scl(input logic v);
    scl = v;
    gap();
  endtask
  task automatic start_c;
    drv_low = 1'b1;
    gap();
    hold_scl(1'b0);
  endtask
  task automatic put_bit(input logic b);
    drv_low = ~b;
    gap();
    hold_scl(1'b1);
    hold_scl(1'b0);
  endtask
  task automatic stop_c;
    drv_low = 1'b1;
    gap();
    hold_scl(1'b1);
    drv_low = 1'b0;
    gap();
  endtask
endmodule

/* File: test/mal_mem_access_tb_top.sv */
// Purpose: Self-checking bench of the memory access block
// Assumes: Core side driven by bench tasks
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module mal_mem_access_tb_top;
  logic clk_sys, rst, core_wdt_rst, si_req, si_we, si_burst, cpu_req, cpu_we, i2c_tx_low, er;
  logic [7:0] lock_code_port, si_wdata, cpu_wdata, si_rdata_ff, cpu_rdata_ff, rd, crc, bits;
  logic [2:0] si_page, cpu_page;
  logic [11:0] si_addr, cpu_addr;
  logic [63:0] si_bwdata, si_brdata_ff;
  logic si_rdy, si_ack_ff, si_err_ff, cpu_rdy, cpu_ack_ff, cpu_err_ff, i2c_sda_out, i2c_sda_oe_ff;
  logic i2c_bit_vld_ff, i2c_bit_ff, i2c_start_ff, i2c_stop_ff, core_reset, locked_ff, scl, sda;
  logic [1:0] interface_protocol_select;
  int fails, total_checks, n_start, n_stop;
  mal_mem_access dut_u (.clk_sys, .rst, .core_wdt_rst, .lock_code_port, .si_req, .si_we, .si_burst,
    .si_page, .si_addr, .si_wdata, .si_bwdata, .si_rdy, .si_ack_ff, .si_err_ff, .si_rdata_ff, .si_brdata_ff,
    .cpu_req, .cpu_we, .cpu_page, .cpu_addr, .cpu_wdata, .cpu_rdy, .cpu_ack_ff, .cpu_err_ff, .cpu_rdata_ff,
    .i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_tx_low, .i2c_sda_out, .i2c_sda_oe_ff, .i2c_bit_vld_ff,
    .i2c_bit_ff, .i2c_start_ff, .i2c_stop_ff, .core_reset, .locked_ff, .interface_protocol_select);
  mal_i2c_mst mst_u (.clk_sys, .dut_oe(i2c_sda_oe_ff), .scl, .sda);
  // ------------
  // Shared tasks
  // ------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (i2c_start_ff === 1'b1) n_start++;
    if (i2c_stop_ff === 1'b1) n_stop++;
    if (i2c_bit_vld_ff === 1'b1) bits = {bits[6:0], i2c_bit_ff};
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic si_op(input logic w, input logic b, input logic [2:0] p, input logic [11:0] a,
    input logic [7:0] d);
    si_req = 1'b1;
    si_we = w;
    si_burst = b;
    si_page = p;
    si_addr = a;
    si_wdata = d;
    chk(si_rdy, "serial ready");
    @(posedge clk_sys);
    #1;
    si_req = 1'b0;
    chk(si_ack_ff, "serial ack");
    rd = si_rdata_ff;
    er = si_err_ff;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic set_lock(input logic [7:0] v);
    lock_code_port = v;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic sw(input logic [2:0] p, input logic [11:0] a, input logic [7:0] d);
    si_op(1'b1, 1'b0, p, a, d);
  endtask
  task automatic sr(input logic [2:0] p, input logic [11:0] a);
    si_op(1'b0, 1'b0, p, a, 8'h00);
  endtask
  task automatic cpu_op(input logic w, input logic [2:0] p, input logic [11:0] a, input logic [7:0] d);
    cpu_req = 1'b1;
    cpu_we = w;
    cpu_page = p;
    cpu_addr = a;
    cpu_wdata = d;
    chk(cpu_rdy, "core ready");
    @(posedge clk_sys);
    #1;
    cpu_req = 1'b0;
    chk(cpu_ack_ff, "core ack");
    rd = cpu_rdata_ff;
    er = cpu_err_ff;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 8'h01;
    while (rd[0] !== 1'b0) begin
      sr(3'h2, 12'h0f3);
      n++;
      if (n > 1500) begin
        chk(1'b0, "engine stuck busy");
        complete_run();
      end
    end
  endtask
  task automatic prog(input logic [2:0] b);
    sw(3'h2, 12'h0f1, {4'h0, b, 1'b1});
    sw(3'h2, 12'h0f2, 8'h02);
    if (b == 3'h1) begin
      sw(3'h5, 12'h550, 8'h00);
      chk(er === 1'b1, "cache write during program");
    end
    wait_idle();
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int k = 0; k < 8; k++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction
  // ---------
  // Scenarios
  // ---------
  task automatic t_enable;
    chk(locked_ff === 1'b0 && interface_protocol_select === 2'h0 && core_reset === 1'b0, "reset state");
    sr(3'h1, 12'h005);
    chk(er === 1'b1, "ram before select");
    sw(3'h0, 12'h000, 8'h01);
    chk(core_reset === 1'b1, "core held");
    sw(3'h0, 12'h000, 8'h03);
    sw(3'h2, 12'h0f0, 8'h01);
    chk(interface_protocol_select === 2'h1, "protocol select");
    sw(3'h1, 12'h0ff, 8'h5a);
    sr(3'h1, 12'h0ff);
    chk(rd === 8'h5a && er === 1'b0, "ram top byte");
    sr(3'h2, 12'h010);
    chk(er === 1'b1, "core register hidden");
    sr(3'h2, 12'h080);
    chk(er === 1'b0, "external register");
    sr(3'h4, 12'hfff);
    chk(er === 1'b0, "program memory end");
    $display("t_enable done");
  endtask
  task automatic t_banks;
    sw(3'h2, 12'h0f1, 8'h03);
    for (int i = 0; i < 16; i++) sw(3'h5, 12'h550 | 12'(i), 8'h10 + 8'(i));
    crc = 8'hff;
    for (int b = 1; b < 5; b++) begin
      prog(3'(b));
      chk(rd[1] === 1'b0, "bank crc");
      for (int i = 0; i < 16; i++) crc = crc8(crc, 8'h10 + 8'(i));
    end
    for (int i = 0; i < 8; i++) crc = crc8(crc, 8'h10 + 8'(i));
    sw(3'h5, 12'h558, crc ^ 8'h01);
    prog(3'h5);
    sr(3'h2, 12'h0f3);
    chk(rd[1] === 1'b1, "wrong total crc flagged");
    sw(3'h2, 12'h0f3, 8'h02);
    sr(3'h2, 12'h0f3);
    chk(rd[1] === 1'b0, "flag cleared");
    sw(3'h5, 12'h558, crc);
    prog(3'h5);
    chk(rd[1] === 1'b0, "right total crc");
    sw(3'h5, 12'h551, 8'hee);
    sw(3'h2, 12'h0f1, 8'h03);
    sw(3'h2, 12'h0f2, 8'h01);
    wait_idle();
    sr(3'h5, 12'h551);
    chk(rd === 8'h11, "cache load");
    si_op(1'b0, 1'b1, 3'h5, 12'h550, 8'h00);
    chk(si_brdata_ff === 64'h1716151413121110, "burst read");
    si_bwdata = {8{crc}};
    si_op(1'b1, 1'b1, 3'h5, 12'h558, 8'h00);
    si_op(1'b0, 1'b1, 3'h5, 12'h558, 8'h00);
    chk(si_brdata_ff === {8{crc}} && er === 1'b0, "burst write");
    $display("t_banks done");
  endtask
  task automatic t_lock;
    sw(3'h0, 12'h000, 8'h02);
    cpu_op(1'b0, 3'h5, 12'h550, 8'h00);
    chk(er === 1'b1, "cache owned by serial");
    cpu_op(1'b0, 3'h0, 12'h000, 8'h00);
    chk(er === 1'b1, "core on test page");
    cpu_op(1'b1, 3'h1, 12'h010, 8'h3c);
    cpu_op(1'b1, 3'h2, 12'h0f1, 8'h02);
    cpu_op(1'b1, 3'h2, 12'h0f2, 8'h02);
    cpu_op(1'b0, 3'h2, 12'h0f3, 8'h00);
    chk(rd[0] === 1'b0, "core cannot program bank 1");
    cpu_op(1'b1, 3'h2, 12'h0f1, 8'h00);
    cpu_op(1'b1, 3'h2, 12'h0f2, 8'h02);
    cpu_op(1'b0, 3'h2, 12'h0f3, 8'h00);
    chk(rd[0] === 1'b1, "core programs bank 0");
    wait_idle();
    chk(rd[1] === 1'b0, "bank 0 without crc");
    set_lock(8'haa);
    set_lock(8'h11);
    sr(3'h1, 12'h010);
    chk(locked_ff === 1'b1 && er === 1'b1, "locked read");
    sw(3'h0, 12'h000, 8'h01);
    chk(er === 1'b1 && core_reset === 1'b0, "control guarded");
    sr(3'h0, 12'h001);
    chk(er === 1'b0, "test page open");
    cpu_op(1'b0, 3'h1, 12'h010, 8'h00);
    chk(rd === 8'h3c && er === 1'b0, "core reads while locked");
    core_wdt_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    core_wdt_rst = 1'b0;
    chk(locked_ff === 1'b1, "lock after watchdog");
    set_lock(8'h00);
    sr(3'h1, 12'h010);
    chk(locked_ff === 1'b0 && rd === 8'h3c && er === 1'b0, "reopened");
    $display("t_lock done");
  endtask
  task automatic t_i2c;
    mst_u.start_c();
    chk(n_start == 1, "start seen");
    mst_u.put_bit(1'b1);
    mst_u.put_bit(1'b0);
    mst_u.put_bit(1'b1);
    mst_u.put_bit(1'b1);
    chk(bits[3:0] === 4'hb, "bits sampled");
    i2c_tx_low = 1'b1;
    mst_u.hold_scl(1'b0);
    chk(i2c_sda_oe_ff === 1'b1 && i2c_sda_out === 1'b0, "drive low");
    mst_u.hold_scl(1'b1);
    i2c_tx_low = 1'b0;
    mst_u.gap();
    chk(i2c_sda_oe_ff === 1'b1, "held while clock high");
    mst_u.hold_scl(1'b0);
    chk(i2c_sda_oe_ff === 1'b0, "released while clock low");
    mst_u.stop_c();
    chk(n_stop == 1, "stop seen");
    $display("t_i2c done");
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    chk(1'b0, "run timeout");
    complete_run();
  end
  initial begin
    rst = 1'b1;
    {core_wdt_rst, si_req, si_we, si_burst, cpu_req, cpu_we, i2c_tx_low} = 7'h00;
    {lock_code_port, si_wdata, cpu_wdata, bits} = 32'h00000000;
    {si_page, cpu_page, si_addr, cpu_addr} = 30'h00000000;
    si_bwdata = 64'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_enable();
    t_banks();
    t_lock();
    t_i2c();
    complete_run();
  end
endmodule
